//--- irq_source_identity_regs.sv
// Interrupt source identity registers with an AXI4-Lite slave
// Functional notes
// - Line 8 has a read-only identity register at 0x20 whose bit 0 shows the timer-0 request.
// - In the line-8 identity field bits 2 and 1 read zero and bit 0 shows the timer-0 request.
// - Line 9 has a read-only identity register at 0x24 showing the timer-1 request in bit 0.
// - Line 12 has a read-only identity register at 0x30 showing the serial port request in bit 0.
// - Line 14 has a read-only identity register at 0x38 showing the SPI port request in bit 0.
// - Line 18 has a read-only identity register at 0x48 showing the I2C request in bit 0.
// - Line 21 has a read-only identity register at 0x54 showing the temperature alarm in bit 0.
// - Line 25 has a read-only identity register at 0x64 for the analog comparator request.
`include "irq_ident_defs.svh"
`default_nettype none

module irq_source_identity_regs #(
  parameter int ADDR_W = 8 // Byte address width
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic timer_zero_request, // Timer 0 request level
  input wire logic timer_one_request, // Timer 1 request level
  input wire logic serial_port_zero_request, // Serial port 0 request level
  input wire logic spi_port_zero_request, // SPI port 0 request level
  input wire logic i2c_ctrl_zero_request, // I2C controller 0 request level
  input wire logic temperature_alarm_request, // Temperature alarm request level
  input wire logic analog_comparator, // Analog comparator request level
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic irq // Level interrupt, any unmasked status bit
);

  // The decode compares eight address bits, so a narrower bus cannot reach the map
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W must be at least 8");
  end

  localparam int NS = `NUM_SOURCES;

  logic [NS-1:0] req_now;
  logic [NS-1:0] req_r;
  logic [NS-1:0] status_r;
  logic [NS-1:0] mask_r;
  logic [NS-1:0] rise;
  logic [NS-1:0] w1c;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic [31:0] rd_nxt;
  logic rd_ok;
  logic wr_fire;
  logic wr_hit;
  irq_ident_pkg::rd_state_t rd_state_r;
  irq_ident_pkg::wr_state_t wr_state_r;

  assign req_now = {analog_comparator, temperature_alarm_request, i2c_ctrl_zero_request,
                    spi_port_zero_request, serial_port_zero_request, timer_one_request,
                    timer_zero_request};

  // Requests are registered once so every identity read sees a clean sampled level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= '0;
    end else begin
      req_r <= req_now;
    end
  end

  assign rise = req_now & ~req_r;

  // Write path: address and data accepted in either order
  assign wr_fire = aw_have_r && w_have_r && (wr_state_r == irq_ident_pkg::WR_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wdata_r <= `ZERO32;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Only status and mask accept writes; identity words silently drop them
  always_comb begin
    wr_hit = 1'b0;
    case (awaddr_r[7:0] & `ADDR_WORD_MASK)
      `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_TIMER0_LINE_SOURCE, `OFS_TIMER1_LINE_SOURCE,
      `OFS_SERIAL0_LINE_SOURCE, `OFS_SPI_PORT0_LINE_SOURCE, `OFS_I2C_CTRL0_LINE_SOURCE,
      `OFS_TEMP_ALARM_LINE_SOURCE, `OFS_COMPARATOR_LINE_SOURCE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  assign w1c = (wr_fire && (awaddr_r[7:0] & `ADDR_WORD_MASK) == `OFS_IRQ_STATUS && wstrb_r[0])
               ? wdata_r[NS-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= irq_ident_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      case (wr_state_r)
        irq_ident_pkg::WR_IDLE: begin
          if (wr_fire) begin
            wr_state_r <= irq_ident_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        irq_ident_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= irq_ident_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state_r <= irq_ident_pkg::WR_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= `MASK_RESET;
    end else if (wr_fire && (awaddr_r[7:0] & `ADDR_WORD_MASK) == `OFS_IRQ_MASK && wstrb_r[0]) begin
      mask_r <= wdata_r[NS-1:0];
    end
  end

  // New request edges win over a simultaneous write-one-to-clear, so no event is lost
  for (genvar i = 0; i < NS; i++) begin : g_status
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        status_r[i] <= 1'b0;
      end else begin
        status_r[i] <= (status_r[i] & ~w1c[i]) | rise[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_r & ~w1c) | rise) & mask_r);
    end
  end

  // Read decode; the identity words sample the registered request, no side effect
  always_comb begin
    rd_nxt = `ZERO32;
    rd_ok = 1'b1;
    case (s_axi_araddr[7:0] & `ADDR_WORD_MASK)
      `OFS_TIMER0_LINE_SOURCE: rd_nxt[0] = req_r[0];
      `OFS_TIMER1_LINE_SOURCE: rd_nxt[0] = req_r[1];
      `OFS_SERIAL0_LINE_SOURCE: rd_nxt[0] = req_r[2];
      `OFS_SPI_PORT0_LINE_SOURCE: rd_nxt[0] = req_r[3];
      `OFS_I2C_CTRL0_LINE_SOURCE: rd_nxt[0] = req_r[4];
      `OFS_TEMP_ALARM_LINE_SOURCE: rd_nxt[0] = req_r[5];
      `OFS_COMPARATOR_LINE_SOURCE: rd_nxt[0] = req_r[6];
      `OFS_IRQ_STATUS: rd_nxt[NS-1:0] = status_r;
      `OFS_IRQ_MASK: rd_nxt[NS-1:0] = mask_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= irq_ident_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `ZERO32;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      case (rd_state_r)
        irq_ident_pkg::RD_IDLE: begin
          s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
          if (s_axi_arvalid && s_axi_arready) begin
            rd_state_r <= irq_ident_pkg::RD_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_nxt;
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        irq_ident_pkg::RD_RESP: begin
          s_axi_arready <= 1'b0;
          if (s_axi_rready) begin
            rd_state_r <= irq_ident_pkg::RD_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
        default: rd_state_r <= irq_ident_pkg::RD_IDLE;
      endcase
    end
  end

endmodule : irq_source_identity_regs
`default_nettype wire

//--- irq_ident_defs.svh
// Register offsets, field layout and reset values for the source identity block
`ifndef IRQ_IDENT_DEFS_SVH
`define IRQ_IDENT_DEFS_SVH

`define OFS_TIMER0_LINE_SOURCE 8'h20
`define OFS_TIMER1_LINE_SOURCE 8'h24
`define OFS_SERIAL0_LINE_SOURCE 8'h30
`define OFS_SPI_PORT0_LINE_SOURCE 8'h38
`define OFS_I2C_CTRL0_LINE_SOURCE 8'h48
`define OFS_TEMP_ALARM_LINE_SOURCE 8'h54
`define OFS_COMPARATOR_LINE_SOURCE 8'h64
`define OFS_IRQ_STATUS 8'h84
`define OFS_IRQ_MASK 8'h88

`define SRC_FIELD_W 3
`define NUM_SOURCES 7
`define ADDR_LSB 2
`define ADDR_WORD_MASK 8'hFC
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO32 32'h0000_0000
`define MASK_RESET 7'h00

`endif

//--- irq_ident_pkg.sv
// Types shared by the source identity block
`default_nettype none
package irq_ident_pkg;
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_RESP
  } rd_state_t;
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_t;
endpackage : irq_ident_pkg
`default_nettype wire

//--- irq_src_chk.sv
// Bus timing and read data checks for the source identity block
`default_nettype none
module irq_src_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [7:0] s_axi_araddr, // ar address
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready // b ready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("late read");
  property p_hi_zero; s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high bits set");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("second read taken");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("read repeated");
  property p_wr_resp; s_axi_awvalid && s_axi_awready |-> ##[2:8] s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write answer");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_id_zero; s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] >= 6'h08 &&
    s_axi_araddr[7:2] <= 6'h19 |=> s_axi_rdata[31:1] == 31'h0; endproperty
  a_id_zero: assert property (p_id_zero) else $error("identity upper bits set");
endmodule : irq_src_chk
bind irq_source_identity_regs irq_src_chk u_chk (.*);
`default_nettype wire

//--- irq_req_src.sv
// Far-side model: peripheral request lines
`default_nettype none
module irq_req_src (
  input wire logic aclk, // clock
  input wire logic [6:0] lvl, // commanded levels
  output logic [6:0] req // requests, timer 0 in bit 0
);
  // Registered like the peripherals' own request flops
  always_ff @(posedge aclk) begin
    req <= lvl;
  end
endmodule : irq_req_src
`default_nettype wire

//--- irq_source_identity_regs_tb_top.sv
// Self-checking bench for the source identity registers
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module irq_source_identity_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] lvl, req;
  logic [33:0] q[$], ex;
  logic [7:0] ofs[7] = '{8'h20, 8'h24, 8'h30, 8'h38, 8'h48, 8'h54, 8'h64};
  int n_mismatch = 0, checks_done = 0;
  irq_req_src u_src (.aclk(aclk), .lvl(lvl), .req(req));
  irq_source_identity_regs u_dut (.*, .timer_zero_request(req[0]), .timer_one_request(req[1]),
    .serial_port_zero_request(req[2]), .spi_port_zero_request(req[3]),
    .i2c_ctrl_zero_request(req[4]), .temperature_alarm_request(req[5]),
    .analog_comparator(req[6]));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic ed(inout int n);
    @(posedge aclk);
    n++;
  endtask : ed
  task automatic lim(input int n);
    if (n >= 50) begin
      n_mismatch++;
      $display("[ERR] %0t bus wait ran out", $time);
      tally_and_finish();
    end
  endtask : lim
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n = 0;
    @(posedge aclk);
    q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do ed(n); while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'h0;
    do ed(n); while (!s_axi_rvalid && n < 50);
    lim(n);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    q.push_back({r, 32'h0});
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      ed(n);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while ((s_axi_awvalid || s_axi_wvalid) && n < 50);
    do ed(n); while (!s_axi_bvalid && n < 50);
    lim(n);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic idchk(input logic [6:0] v);
    lvl <= v;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 7; i++) rd(ofs[i], {33'h0, v[i]});
  endtask : idchk
  // Notes are taken in order, so one queue serves reads and writes alike
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      ex = q.pop_front();
      if (s_axi_rvalid) `CHK({s_axi_rresp, s_axi_rdata}, ex)
      else `CHK({s_axi_bresp, 32'h0}, ex)
    end
  end
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lvl} = '0;
    s_axi_wstrb = 4'hF;
    rnd = 32'h7D68;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    idchk(7'h00);
    for (int i = 0; i < 7; i++) idchk(7'h01 << i);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      idchk(rnd[6:0]);
    end
    $display("identity test done");
    wr(8'h64, 32'hFFFF_FFFF, 2'h0);
    idchk(rnd[6:0]);
    rd(8'h40, {2'h2, 32'h0});
    wr(8'h40, 32'h1, 2'h2);
    $display("access test done");
    lvl <= 7'h00;
    wr(8'h84, 32'h7F, 2'h0);
    rd(8'h88, {2'h0, 32'h0});
    wr(8'h88, 32'h1, 2'h0);
    lvl <= 7'h02;
    repeat (4) @(posedge aclk);
    `CHK(irq, 1'h0)
    lvl <= 7'h03;
    repeat (4) @(posedge aclk);
    `CHK(irq, 1'h1)
    rd(8'h84, {2'h0, 32'h3});
    rd(8'h84, {2'h0, 32'h3});
    wr(8'h84, 32'h1, 2'h0);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'h0)
    rd(8'h84, {2'h0, 32'h2});
    $display("interrupt test done");
    tally_and_finish();
  end
endmodule : irq_source_identity_regs_tb_top
`default_nettype wire
